// [include/watch_peak_pkg.sv]
// package: register map, field layout, resets and carriers for window/peak
package watch_peak_pkg;

	localparam int unsigned ADDR_W = 8;            // register address width
	localparam int unsigned DATA_W = 8;            // register data width
	localparam int unsigned CODE_W = 12;           // conversion result width

	// register offsets
	localparam logic [7:0] OFS_HYST_HIGH_NIB  = 8'h3c;
	localparam logic [7:0] OFS_UPPER_BYTE     = 8'h3d;
	localparam logic [7:0] OFS_COUNT_LOW_NIB  = 8'h3e;
	localparam logic [7:0] OFS_LOWER_BYTE     = 8'h3f;
	localparam logic [7:0] OFS_PEAK_LOW       = 8'h60;
	localparam logic [7:0] OFS_PEAK_HIGH      = 8'h61;

	// field positions inside the nibble-sharing registers
	localparam int unsigned NIB_HI_LSB  = 4;       // threshold nibble at 7:4
	localparam int unsigned NIB_LO_LSB  = 0;       // setting nibble at 3:0
	localparam int unsigned HYST_SHIFT  = 3;       // hysteresis scale shift

	// reset values
	localparam logic [7:0] RST_HYST_HIGH_NIB = 8'hf0;
	localparam logic [7:0] RST_UPPER_BYTE    = 8'hff;
	localparam logic [7:0] RST_COUNT_LOW_NIB = 8'h00;
	localparam logic [7:0] RST_LOWER_BYTE    = 8'h00;
	localparam logic [7:0] RST_PEAK_BYTE     = 8'h00;

	// register access request from the device's command logic
	typedef struct packed {
		logic       wr;                          // write strobe
		logic       rd;                          // read strobe
		logic [7:0] addr;                        // register offset
		logic [7:0] wdata;                       // write data
	} reg_req_type;

	// window configuration handed to the comparator
	typedef struct packed {
		logic [11:0] upper;                      // full high limit
		logic [11:0] lower;                      // full low limit
		logic [6:0]  hyst;                       // scaled hysteresis
		logic [3:0]  count;                      // n of n+1 samples
	} window_cfg_type;

endpackage : watch_peak_pkg

// [design/window_checker.sv]
// module: hysteresis window comparator with consecutive-sample counter
`timescale 1ns/100ps
`default_nettype none

module window_checker #(
	parameter int unsigned CODE_W = 12       // conversion result width
) (
	input  wire logic                          i_clock,
	input  wire logic                          i_resetn,
	input  wire logic                          i_sample_valid,
	input  wire logic [CODE_W-1:0]             i_sample_code,
	input  wire watch_peak_pkg::window_cfg_type i_cfg,
	output logic                               o_event,
	output logic                               o_alarm_state
);

	// elaboration-time refusal: the limit layout is fixed at twelve bits
	if (CODE_W != 12) begin : g_code_w_check
		$error("window_checker serves 12-bit codes only");
	end

	logic        alarm_ff;                     // currently outside window
	logic [4:0]  run_ff;                       // consecutive outside samples
	logic        event_ff;                     // one-cycle event pulse
	logic [4:0]  nxt_run;
	logic        nxt_alarm;
	logic        nxt_event;

	// hysteresis pulls each limit toward the window once alarmed, so a
	// code jittering at the edge does not chatter the flag
	wire  [12:0] high_rel = {1'b0, i_cfg.upper} - {6'h00, i_cfg.hyst};
	wire  [12:0] low_rel  = {1'b0, i_cfg.lower} + {6'h00, i_cfg.hyst};
	wire         above    = i_sample_code > i_cfg.upper;
	wire         below    = i_sample_code < i_cfg.lower;
	wire         still_hi = high_rel[12] ? 1'b1
		: ({1'b0, i_sample_code} > high_rel);
	wire         still_lo = {1'b0, i_sample_code} < low_rel;
	wire         outside  = alarm_ff ? (still_hi || still_lo)
		: (above || below);
	wire  [4:0]  need     = {1'b0, i_cfg.count} + 5'h01;

	// count runs of outside samples; an inside sample restarts the run
	always_comb begin
		nxt_run   = run_ff;
		nxt_alarm = alarm_ff;
		nxt_event = 1'b0;
		if (i_sample_valid) begin
			if (!outside) begin
				nxt_run   = 5'h00;
				nxt_alarm = 1'b0;
			end else if (run_ff + 5'h01 >= need) begin
				nxt_run   = need;                        // saturate at n+1
				nxt_event = !alarm_ff;
				nxt_alarm = 1'b1;
			end else begin
				nxt_run = run_ff + 5'h01;
			end
		end
	end

	// state registers
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			run_ff   <= 5'h00;
			alarm_ff <= 1'b0;
			event_ff <= 1'b0;
		end else begin
			run_ff   <= nxt_run;
			alarm_ff <= nxt_alarm;
			event_ff <= nxt_event;
		end
	end

	assign o_event       = event_ff;
	assign o_alarm_state = alarm_ff;

	// an event pulse needs n+1 outside samples counted in the run
	a_event_needs_run: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		o_event |-> run_ff == need)
		else $error("event before n+1 samples");

endmodule : window_checker

`default_nettype wire

// [design/window_peak_top.sv]
// module: channel window watchdog registers and peak-code recorder
//
// Operation
// - high limit is top byte plus nibble
// - low limit is top byte plus nibble
// - threshold bytes match result bits eleven to four
// - hysteresis nibble shifted three, both limits
// - event after n+1 consecutive outside samples
// - track maximum code as low/high bytes
// - reading either peak byte clears the whole peak
// - reset leaves window fully open
`timescale 1ns/100ps
`default_nettype none

module window_peak_top #(
	parameter int unsigned CODE_W = 12       // conversion result width
) (
	input  wire logic                         i_clock,
	input  wire logic                         i_resetn,
	input  wire watch_peak_pkg::reg_req_type  i_req,
	input  wire logic                         i_win_valid,
	input  wire logic [CODE_W-1:0]            i_win_code,
	input  wire logic                         i_peak_valid,
	input  wire logic [CODE_W-1:0]            i_peak_code,
	output logic [7:0]                        o_rdata,
	output logic                              o_rvalid,
	output logic                              o_event,
	output logic                              o_alarm_state
);

	// elaboration-time refusal: byte plus nibble only spans twelve bits
	if (CODE_W != 12) begin : g_code_w_check
		$error("window_peak_top serves 12-bit codes only");
	end

	// configuration, peak and read-answer registers
	logic [7:0]  hyst_nib_ff;                  // high nibble + hysteresis
	logic [7:0]  upper_ff;                     // high threshold top byte
	logic [7:0]  count_nib_ff;                 // low nibble + event count
	logic [7:0]  lower_ff;                     // low threshold top byte
	logic [11:0] peak_ff;                      // largest code since read
	logic [7:0]  rdata_ff;                     // registered read data
	logic        rvalid_ff;                    // read answer strobe
	logic        event_w;
	logic        alarm_w;
	logic        event_ff;
	logic        alarm_ff;

	// address decode
	wire wr_hyst  = i_req.wr && i_req.addr == watch_peak_pkg::OFS_HYST_HIGH_NIB;
	wire wr_upper = i_req.wr && i_req.addr == watch_peak_pkg::OFS_UPPER_BYTE;
	wire wr_count = i_req.wr && i_req.addr == watch_peak_pkg::OFS_COUNT_LOW_NIB;
	wire wr_lower = i_req.wr && i_req.addr == watch_peak_pkg::OFS_LOWER_BYTE;
	wire rd_plo   = i_req.rd && i_req.addr == watch_peak_pkg::OFS_PEAK_LOW;
	wire rd_phi   = i_req.rd && i_req.addr == watch_peak_pkg::OFS_PEAK_HIGH;
	wire rd_peak  = rd_plo || rd_phi;

	// nibbles cut out of the shared registers at their package positions
	wire [3:0] upper_limit_low_nibble =
		hyst_nib_ff[watch_peak_pkg::NIB_HI_LSB +: 4];
	wire [3:0] window_hyst_setting =
		hyst_nib_ff[watch_peak_pkg::NIB_LO_LSB +: 4];
	wire [3:0] lower_limit_low_nibble =
		count_nib_ff[watch_peak_pkg::NIB_HI_LSB +: 4];
	wire [3:0] consecutive_sample_count =
		count_nib_ff[watch_peak_pkg::NIB_LO_LSB +: 4];

	// assemble the twelve-bit limits: byte on top, nibble below
	watch_peak_pkg::window_cfg_type cfg;
	assign cfg.upper = {upper_ff, upper_limit_low_nibble};
	assign cfg.lower = {lower_ff, lower_limit_low_nibble};
	// hysteresis is the setting with three zero bits below it
	assign cfg.hyst  =
		7'(window_hyst_setting) << watch_peak_pkg::HYST_SHIFT;
	assign cfg.count = consecutive_sample_count;

	// peak byte view: low byte is code 7:0, high byte holds 11:8
	wire [7:0] peak_lo = peak_ff[7:0];
	wire [7:0] peak_hi = {4'h0, peak_ff[11:8]};

	// read mux; unmapped offsets read zero
	wire [7:0] rd_mux =
		(i_req.addr == watch_peak_pkg::OFS_HYST_HIGH_NIB) ? hyst_nib_ff :
		(i_req.addr == watch_peak_pkg::OFS_UPPER_BYTE)    ? upper_ff :
		(i_req.addr == watch_peak_pkg::OFS_COUNT_LOW_NIB) ? count_nib_ff :
		(i_req.addr == watch_peak_pkg::OFS_LOWER_BYTE)    ? lower_ff :
		rd_plo ? peak_lo :
		rd_phi ? peak_hi : 8'h00;

	// a new sample in the read cycle still counts: it wins over the clear
	wire        new_max  = i_peak_valid && (i_peak_code > peak_ff);
	wire [11:0] nxt_peak = rd_peak ? (i_peak_valid ? i_peak_code : 12'h000)
		: (new_max ? i_peak_code : peak_ff);

	window_checker #(
		.CODE_W (CODE_W)
	) u_checker (
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_sample_valid (i_win_valid),
		.i_sample_code  (i_win_code),
		.i_cfg          (cfg),
		.o_event        (event_w),
		.o_alarm_state  (alarm_w)
	);

	// configuration writes
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			hyst_nib_ff  <= watch_peak_pkg::RST_HYST_HIGH_NIB;
			upper_ff     <= watch_peak_pkg::RST_UPPER_BYTE;
			count_nib_ff <= watch_peak_pkg::RST_COUNT_LOW_NIB;
			lower_ff     <= watch_peak_pkg::RST_LOWER_BYTE;
		end else begin
			if (wr_hyst)  hyst_nib_ff  <= i_req.wdata;
			if (wr_upper) upper_ff     <= i_req.wdata;
			if (wr_count) count_nib_ff <= i_req.wdata;
			if (wr_lower) lower_ff     <= i_req.wdata;
		end
	end

	// peak tracking and clear-on-read
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			peak_ff <= 12'h000;
		end else begin
			peak_ff <= nxt_peak;
		end
	end

	// read answer and flopped outputs
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
			event_ff  <= 1'b0;
			alarm_ff  <= 1'b0;
		end else begin
			rdata_ff  <= i_req.rd ? rd_mux : rdata_ff;
			rvalid_ff <= i_req.rd;
			event_ff  <= event_w;
			alarm_ff  <= alarm_w;
		end
	end

	assign o_rdata       = rdata_ff;
	assign o_rvalid      = rvalid_ff;
	assign o_event       = event_ff;
	assign o_alarm_state = alarm_ff;

	// reference limits rebuilt straight from the register bytes, so the
	// alarm and band checks below do not lean on the cfg carrier that they guard
	wire [11:0] up_lim   = {upper_ff, hyst_nib_ff[7:4]};
	wire [11:0] lo_lim   = {lower_ff, count_nib_ff[7:4]};
	wire        out_raw  = i_win_code > up_lim || i_win_code < lo_lim;
	wire [12:0] hyst_amt = 13'(hyst_nib_ff[3:0]) * 13'd8;
	wire        hi_band  = ({1'b0, i_win_code} + hyst_amt) > {1'b0, up_lim};
	wire        lo_band  = {1'b0, i_win_code} < ({1'b0, lo_lim} + hyst_amt);

	// a read with no sample in the same cycle empties the recorder
	a_peak_clears: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		rd_peak && !i_peak_valid |=> peak_ff == 12'h000)
		else $error("peak not cleared by read");

	// a larger code replaces the stored peak
	a_peak_grows: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!rd_peak && new_max |=> peak_ff == $past(i_peak_code))
		else $error("peak missed a larger code");

	// without a read the stored peak never falls
	a_peak_holds: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		!rd_peak |=> peak_ff >= $past(peak_ff))
		else $error("peak fell without a read");

	// low byte answer carries code bits seven to zero
	a_peak_read_data: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		rd_plo |=> o_rvalid && o_rdata == $past(peak_ff[7:0]))
		else $error("peak low byte read wrong");

	// high byte answer carries code bits eleven to eight
	a_peak_high_read: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		rd_phi |=> o_rvalid && o_rdata == {4'h0, $past(peak_ff[11:8])})
		else $error("peak high byte read wrong");

	// a sample inside both limits never raises the alarm
	a_high_limit: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		i_win_valid && !alarm_w && !out_raw |=> !alarm_w)
		else $error("alarm raised inside the window");

	// alarm entry only follows a sample beyond a limit
	a_low_limit: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		$rose(alarm_w) |-> $past(i_win_valid) && $past(out_raw))
		else $error("alarm entered without an outside sample");

	// inside the hysteresis band an alarm holds
	a_hyst_scale: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		i_win_valid && alarm_w && (hi_band || lo_band) |=> alarm_w)
		else $error("alarm dropped inside hysteresis band");

	// beyond the hysteresis band an alarm releases
	a_hyst_release: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		i_win_valid && alarm_w && !hi_band && !lo_band |=> !alarm_w)
		else $error("alarm kept past hysteresis band");

	// a written threshold byte lands in the top of the limit
	a_byte_align: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		wr_upper |=> cfg.upper[11:4] == $past(i_req.wdata))
		else $error("threshold byte not top aligned");

	// entry into alarm shows as an event pulse one edge later
	a_event_delay: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		$rose(alarm_w) |=> o_event && o_alarm_state)
		else $error("event not forwarded");

	// an event lasts exactly one cycle
	a_event_single: assert property (
		@(posedge i_clock) disable iff (!i_resetn)
		o_event |=> !o_event)
		else $error("event pulse too long");

	// right after reset the window spans every code
	a_reset_open: assert property (
		@(posedge i_clock)
		$rose(i_resetn) |-> cfg.upper == 12'hfff && cfg.lower == 12'h000)
		else $error("window not open after reset");

endmodule : window_peak_top

`default_nettype wire

// [tb/tb.sv]
// testbench: registers, window events and peak tracking of window_peak_top
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic                        i_clock;        // 20 MHz device clock
	logic                        i_resetn;       // async reset, active low
	watch_peak_pkg::reg_req_type req;            // register request
	logic                        win_valid;      // window sample strobe
	logic [11:0]                 win_code;       // window sample code
	logic                        peak_valid;     // peak sample strobe
	logic [11:0]                 peak_code;      // peak sample code
	logic [7:0]                  rdata;          // read data
	logic                        rvalid;         // read answer pulse
	logic                        event_p;        // window event pulse
	logic                        alarm;          // window alarm level
	logic [7:0]                  exp_q[$];       // expected read data notes
	logic [7:0]                  adr_q[$];       // address of each note
	int                          n_mismatch;     // mismatches seen
	int                          checked;        // comparisons made
	int                          n_event;        // event pulses seen
	int                          cyc;            // cycles since start
	logic [31:0]                 rnd;            // xorshift state
	logic [11:0]                 pmax;           // model of peak value

	window_peak_top #(.CODE_W(12)) dut (
		.i_clock      (i_clock),
		.i_resetn     (i_resetn),
		.i_req        (req),
		.i_win_valid  (win_valid),
		.i_win_code   (win_code),
		.i_peak_valid (peak_valid),
		.i_peak_code  (peak_code),
		.o_rdata      (rdata),
		.o_rvalid     (rvalid),
		.o_event      (event_p),
		.o_alarm_state(alarm)
	);

	// free-running clock, 50 ns period
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	// xorshift, fixed seed so runs repeat
	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction : xs

	task automatic end_sim();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [7:0] e, g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one-cycle request, then idle; reads leave a note for the monitor
	task automatic acc(input logic w, input logic [7:0] a, d, e);
		@(posedge i_clock);
		req <= '{wr: w, rd: ~w, addr: a, wdata: d};
		if (!w) begin
			exp_q.push_back(e);
			adr_q.push_back(a);
		end
		@(posedge i_clock);
		req <= '0;
	endtask : acc

	// window samples, two cycles apart
	task automatic smp(input logic [11:0] c, input int k);
		repeat (k) begin
			@(posedge i_clock);
			win_valid <= 1'b1;
			win_code  <= c;
			@(posedge i_clock);
			win_valid <= 1'b0;
		end
		repeat (4) @(posedge i_clock);
	endtask : smp

	task automatic psmp(input logic [11:0] c);
		@(posedge i_clock);
		peak_valid <= 1'b1;
		peak_code  <= c;
		if (c > pmax) pmax = c;
		@(posedge i_clock);
		peak_valid <= 1'b0;
	endtask : psmp

	// monitor: oldest note against each read answer
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (event_p === 1'b1) n_event <= n_event + 1;
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected rvalid", 8'h00, 8'hff);
			end else begin
				checked++;
				if (rdata !== exp_q[0]) begin
					n_mismatch++;
					$display("ERROR rdata at %h expected %h seen %h",
						adr_q[0], exp_q[0], rdata);
				end
				void'(exp_q.pop_front());
				void'(adr_q.pop_front());
			end
		end
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		i_resetn = 1'b0;
		req = '0;
		win_valid = 1'b0;
		win_code = 12'h000;
		peak_valid = 1'b0;
		peak_code = 12'h000;
		n_mismatch = 0;
		checked = 0;
		n_event = 0;
		cyc = 0;
		rnd = 32'd39455;
		pmax = 12'h000;
		repeat (6) @(posedge i_clock);
		i_resetn <= 1'b1;
		// reset values, unmapped address reads zero
		acc(1'b0, 8'h3c, 8'h00, watch_peak_pkg::RST_HYST_HIGH_NIB);
		acc(1'b0, 8'h3d, 8'h00, watch_peak_pkg::RST_UPPER_BYTE);
		acc(1'b0, 8'h3e, 8'h00, watch_peak_pkg::RST_COUNT_LOW_NIB);
		acc(1'b0, 8'h3f, 8'h00, watch_peak_pkg::RST_LOWER_BYTE);
		acc(1'b0, 8'h61, 8'h00, 8'h00);
		acc(1'b0, 8'h10, 8'h00, 8'h00);
		// window: upper 0x805, lower 0x103, hysteresis 2 -> 0x10, n = 2
		acc(1'b1, 8'h3c, 8'h52, 8'h00);
		acc(1'b1, 8'h3d, 8'h80, 8'h00);
		acc(1'b1, 8'h3e, 8'h32, 8'h00);
		acc(1'b1, 8'h3f, 8'h10, 8'h00);
		acc(1'b1, 8'h60, 8'haa, 8'h00);
		acc(1'b0, 8'h3c, 8'h00, 8'h52);
		acc(1'b0, 8'h3e, 8'h00, 8'h32);
		acc(1'b0, 8'h60, 8'h00, 8'h00);
		smp(12'h805, 3);
		chk("event at limit", 8'd0, 8'(n_event));
		smp(12'h806, 2);
		smp(12'h500, 1);
		smp(12'h806, 2);
		chk("event broken run", 8'd0, 8'(n_event));
		smp(12'h806, 1);
		chk("event high", 8'd1, 8'(n_event));
		chk("alarm high", 8'd1, 8'(alarm));
		smp(12'h7f6, 1);
		chk("alarm in hysteresis", 8'd1, 8'(alarm));
		chk("no repeat event", 8'd1, 8'(n_event));
		smp(12'h7f5, 1);
		chk("alarm released", 8'd0, 8'(alarm));
		smp(12'h103, 3);
		chk("event at low limit", 8'd1, 8'(n_event));
		smp(12'h102, 3);
		chk("event low", 8'd2, 8'(n_event));
		smp(12'h112, 1);
		chk("low hysteresis", 8'd1, 8'(alarm));
		// peak tracking with random codes, clear on each read
		repeat (8) psmp(12'(xs() >> 20));
		acc(1'b0, 8'h60, 8'h00, pmax[7:0]);
		acc(1'b0, 8'h61, 8'h00, 8'h00);
		pmax = 12'h000;
		repeat (4) psmp(12'(xs() >> 20));
		acc(1'b0, 8'h61, 8'h00, {4'h0, pmax[11:8]});
		acc(1'b0, 8'h60, 8'h00, 8'h00);
		repeat (4) @(posedge i_clock);
		chk("notes left", 8'd0, 8'(exp_q.size()));
		end_sim();
	end
endmodule : tb

`default_nettype wire
